/* File: logic/hpw_port_regs.vh */
// Purpose: Constants for the host write port.
// Assumes: Core clock of 200 MHz; host strobes are asynchronous to it.
// Notes:   Definitions only.
`ifndef HPW_PORT_REGS_VH
`define HPW_PORT_REGS_VH

// ----------------------------------------------------------------------------
// Clock and host timing
// ----------------------------------------------------------------------------
`define HPW_CLK_PERIOD_PS    5000
`define HPW_T_CYCLE_NS       45
`define HPW_T_ACTIVE_NS      32
`define HPW_T_IDLE_NS        13
`define HPW_T_DSU_NS         7
// Least cycle counts, rounded up.
`define HPW_CYC(ns)          (((ns) * 1000 + `HPW_CLK_PERIOD_PS - 1) / `HPW_CLK_PERIOD_PS)

// ----------------------------------------------------------------------------
// Bus layout
// ----------------------------------------------------------------------------
`define HPW_DATA_W           32
`define HPW_ADDR_W           7
`define HPW_HALF_W           16
`define HPW_LOW_ADDR_MSB     1
`define HPW_UPPER_ADDR_LSB   2
// Word address (in 16-bit units, A[7:1]) of the transmit data port.
`define HPW_TXFIFO_ADDR      7'h10
`define HPW_TXFIFO_ADDR_MSK  7'h7c
// Receive FIFO word address used by decoded (non-direct) reads.
`define HPW_RXFIFO_ADDR      7'h00

// ----------------------------------------------------------------------------
// Sequencer states
// ----------------------------------------------------------------------------
`define HPW_ST_IDLE          2'h0
`define HPW_ST_WRITE         2'h1
`define HPW_ST_READ          2'h2

`endif

/* File: logic/hpw_port.v */
// Purpose: Host programmed-write port with transmit FIFO direct mode and
//          receive FIFO direct burst read framing.
// Assumes: Host strobes, address and data are asynchronous pins and are
//          synchronised by two flip-flops before use.
// Notes:   Writes are captured at the end of the cycle, on strobe or select release.
//          The word is taken from the last sample in which the cycle was
//          still on, so the host may drop its data as the strobe rises.
`timescale 1ns/1ps
`include "hpw_port_regs.vh"

// Overview of operation
// RULE1: Write cycle begins when select and strobe low.
// RULE2: Host keeps released strobe high 13 ns.
// RULE3: Host keeps 45 ns cycle, 32 ns active.
// RULE4: Data is captured when cycle ends.
// RULE5: Upper data half ignored on 16-bit writes.
// RULE6: Direct select routes writes to transmit FIFO.
// RULE7: Direct mode keeps low address, ignores upper.
// RULE8: Direct select sampled like address bits.
// RULE9: Direct burst read framed by select and read.
// RULE10: Burst reads unlimited; released strobes stay high.
// RULE11: Each completed FIFO write pushes one word.
module hpw_port (
    // Clock, reset and enable.
    input  wire                     core_clk,
    input  wire                     srst,
    input  wire                     clkEn,
    // Host pins.
    input  wire                     bus_select_n,
    input  wire                     write_strobe_n,
    input  wire                     read_strobe_n,
    input  wire                     fifoDirectSel,
    input  wire [`HPW_ADDR_W-1:0]   hostAddr,
    input  wire [`HPW_DATA_W-1:0]   hostData,
    // Bus width strap: high for a 32-bit host bus.
    input  wire                     busWide,
    // Transmit FIFO write side.
    output reg                      txPush,
    output reg  [`HPW_DATA_W-1:0]   txData,
    // Register write side for every other address.
    output reg                      regWrite,
    output reg  [`HPW_ADDR_W-1:0]   regAddr,
    output reg  [`HPW_DATA_W-1:0]   regData,
    // Receive FIFO direct read framing.
    output reg                      rxPop,
    output reg  [`HPW_LOW_ADDR_MSB:0] rxLowAddr,
    output reg                      readActive
);

    // ------------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------------
    reg [2:0]                 ctlMeta_reg;
    reg [2:0]                 ctlSync_reg;
    reg                       selMeta_reg;
    reg                       selSync_reg;
    reg                       wideMeta_reg;
    reg                       wideSync_reg;
    reg [`HPW_ADDR_W-1:0]     addrMeta_reg;
    reg [`HPW_ADDR_W-1:0]     addrSync_reg;
    reg [`HPW_DATA_W-1:0]     dataMeta_reg;
    reg [`HPW_DATA_W-1:0]     dataSync_reg;
    // Data one sample older, lined up with the last low strobe sample.
    reg [`HPW_DATA_W-1:0]     dataLast_reg;

    // ------------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------------
    reg [1:0]                 state_reg;
    reg [1:0]                 state_next;
    reg                       cycSel_reg;
    reg [`HPW_ADDR_W-1:0]     cycAddr_reg;
    reg                       cycWide_reg;
    reg                       cycSel_next;
    reg [`HPW_ADDR_W-1:0]     cycAddr_next;
    reg                       cycWide_next;

    wire writeOn = ~ctlSync_reg[0] & ~ctlSync_reg[1];  // see RULE1
    wire readOn  = ~ctlSync_reg[0] & ~ctlSync_reg[2];  // see RULE9

    // ------------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------------

    // Returns true when a cycle reaches the transmit data FIFO.
    function isTxTarget;
        input                   sel;
        input [`HPW_ADDR_W-1:0] addr;
        begin
            // Direct mode skips decode of the upper address.
            // Only the low address pair may matter there.  // see RULE7
            isTxTarget = sel |
                ((addr & `HPW_TXFIFO_ADDR_MSK) == `HPW_TXFIFO_ADDR);  // see RULE6
        end
    endfunction

    // Drops the upper data half on a narrow bus.
    function [`HPW_DATA_W-1:0] laneMask;
        input                   wide;
        input [`HPW_DATA_W-1:0] d;
        begin
            laneMask = wide ? d : {{`HPW_HALF_W{1'b0}}, d[`HPW_HALF_W-1:0]};  // see RULE5
        end
    endfunction

    // ------------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------------

    // Two flip-flops on every pin; only the second stage is read, except for data.
    // A third data stage keeps the word valid although no data hold is owed.
    always @(posedge core_clk) begin
        if (srst) begin
            ctlMeta_reg  <= 3'h7;
            ctlSync_reg  <= 3'h7;
            selMeta_reg  <= 1'b0;
            selSync_reg  <= 1'b0;
            wideMeta_reg <= 1'b1;
            wideSync_reg <= 1'b1;
            addrMeta_reg <= {`HPW_ADDR_W{1'b0}};
            addrSync_reg <= {`HPW_ADDR_W{1'b0}};
            dataMeta_reg <= {`HPW_DATA_W{1'b0}};
            dataSync_reg <= {`HPW_DATA_W{1'b0}};
            dataLast_reg <= {`HPW_DATA_W{1'b0}};
        end else if (clkEn) begin
            ctlMeta_reg  <= {read_strobe_n, write_strobe_n, bus_select_n};
            ctlSync_reg  <= ctlMeta_reg;
            selMeta_reg  <= fifoDirectSel;
            selSync_reg  <= selMeta_reg;
            wideMeta_reg <= busWide;
            wideSync_reg <= wideMeta_reg;
            addrMeta_reg <= hostAddr;
            addrSync_reg <= addrMeta_reg;
            dataMeta_reg <= hostData;
            dataSync_reg <= dataMeta_reg;
            dataLast_reg <= dataSync_reg;
        end
    end

    // ------------------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------------------

    // Next state: a cycle starts on joint assertion and ends on any release.
    always @* begin
        state_next   = state_reg;
        cycSel_next  = cycSel_reg;
        cycAddr_next = cycAddr_reg;
        cycWide_next = cycWide_reg;
        case (state_reg)
            `HPW_ST_IDLE: begin
                // Direct select and address are taken together at cycle start.
                cycSel_next  = selSync_reg;  // see RULE8
                cycAddr_next = addrSync_reg;
                cycWide_next = wideSync_reg;
                // A write wins when both strobes are low together.
                if (writeOn) begin
                    state_next = `HPW_ST_WRITE;  // see RULE1
                end else if (readOn) begin
                    state_next = `HPW_ST_READ;  // see RULE9
                end
            end
            `HPW_ST_WRITE: begin
                if (!writeOn) begin
                    state_next = `HPW_ST_IDLE;  // see RULE1
                end
            end
            `HPW_ST_READ: begin
                // Each released strobe closes one read of an unlimited burst.
                if (!readOn) begin
                    state_next = `HPW_ST_IDLE;  // see RULE10
                end
            end
            default: begin
                state_next = `HPW_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    // State, capture and output registers.
    always @(posedge core_clk) begin
        if (srst) begin
            state_reg   <= `HPW_ST_IDLE;
            cycSel_reg  <= 1'b0;
            cycAddr_reg <= {`HPW_ADDR_W{1'b0}};
            cycWide_reg <= 1'b1;
            txPush      <= 1'b0;
            txData      <= {`HPW_DATA_W{1'b0}};
            regWrite    <= 1'b0;
            regAddr     <= {`HPW_ADDR_W{1'b0}};
            regData     <= {`HPW_DATA_W{1'b0}};
            rxPop       <= 1'b0;
            rxLowAddr   <= 2'h0;
            readActive  <= 1'b0;
        end else if (clkEn) begin
            state_reg   <= state_next;
            cycSel_reg  <= cycSel_next;
            cycAddr_reg <= cycAddr_next;
            cycWide_reg <= cycWide_next;
            txPush      <= 1'b0;
            regWrite    <= 1'b0;
            rxPop       <= 1'b0;
            readActive  <= (state_next == `HPW_ST_READ);
            // Write end: the word from the last sample before the release.
            if (state_reg == `HPW_ST_WRITE && !writeOn) begin
                if (isTxTarget(cycSel_reg, cycAddr_reg)) begin
                    txPush <= 1'b1;  // see RULE11
                    txData <= laneMask(cycWide_reg, dataLast_reg);  // see RULE4
                end else begin
                    regWrite <= 1'b1;
                    regAddr  <= cycAddr_reg;
                    regData  <= laneMask(cycWide_reg, dataLast_reg);  // see RULE4
                end
            end
            // Read end: one word leaves the receive FIFO in direct mode or at the decoded receive FIFO address.
            if (state_reg == `HPW_ST_READ && !readOn &&
                (cycSel_reg || cycAddr_reg == `HPW_RXFIFO_ADDR)) begin
                rxPop     <= 1'b1;  // see RULE9
                rxLowAddr <= cycAddr_reg[`HPW_LOW_ADDR_MSB:0];  // see RULE7
            end
        end
    end

endmodule // hpw_port

/* File: bench/hpw_port_monitor.sv */
// Purpose: Port checks for the host write port.
// Assumes: Pulses follow a cycle end by three clocks.
// Notes:   Bound to every hpw_port.
`timescale 1ns/1ps
`include "hpw_port_regs.vh"
module hpw_port_monitor (
    // Clock, reset and host pins.
    input wire                         core_clk,
    input wire                         srst,
    input wire                         bus_select_n,
    input wire                         write_strobe_n,
    input wire                         read_strobe_n,
    input wire                         fifoDirectSel,
    input wire [`HPW_ADDR_W-1:0]       hostAddr,
    input wire [`HPW_DATA_W-1:0]       hostData,
    input wire                         busWide,
    // Outputs watched.
    input wire                         txPush,
    input wire [`HPW_DATA_W-1:0]       txData,
    input wire                         regWrite,
    input wire                         rxPop,
    input wire [`HPW_LOW_ADDR_MSB:0]   rxLowAddr,
    input wire                         readActive
);
    wire [`HPW_LOW_ADDR_MSB:0] hostLowAddr = hostAddr[`HPW_LOW_ADDR_MSB:0];
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // Pushes come only after a joint assertion has ended.
    a_push_after_end: assert property (txPush |->
        ($past(bus_select_n, 3) || $past(write_strobe_n, 3))
        && !$past(bus_select_n, 4) && !$past(write_strobe_n, 4))
        else $error("push not at cycle end");
    a_push_single: assert property (txPush |=> !txPush)
        else $error("push longer than one cycle");
    a_reg_not_direct: assert property (regWrite |-> !$past(fifoDirectSel, 3))
        else $error("direct write reached registers");
    a_data_at_end: assert property (txPush && busWide |-> txData == $past(hostData, 4))
        else $error("word not taken at cycle end");
    a_half_upper: assert property (txPush && !busWide |-> txData[31:16] == 16'h0000)
        else $error("upper half kept on narrow bus");
    a_pop_low_addr: assert property (rxPop |-> rxLowAddr == $past(hostLowAddr, 3))
        else $error("wrong low address on pop");
    a_pop_single: assert property (rxPop |=> !rxPop)
        else $error("pop longer than one cycle");
    a_read_frame: assert property ($fell(read_strobe_n) && !bus_select_n && write_strobe_n
        |-> ##[1:3] readActive) else $error("read cycle not seen");
    c_push: cover property (txPush);
    c_reg: cover property (regWrite);
    c_pop: cover property (rxPop);
endmodule // hpw_port_monitor

bind hpw_port hpw_port_monitor i_mon (
    .core_clk       (core_clk),
    .srst           (srst),
    .bus_select_n   (bus_select_n),
    .write_strobe_n (write_strobe_n),
    .read_strobe_n  (read_strobe_n),
    .fifoDirectSel  (fifoDirectSel),
    .hostAddr       (hostAddr),
    .hostData       (hostData),
    .busWide        (busWide),
    .txPush         (txPush),
    .txData         (txData),
    .regWrite       (regWrite),
    .rxPop          (rxPop),
    .rxLowAddr      (rxLowAddr),
    .readActive     (readActive)
);

/* File: bench/hpw_host_model.sv */
// Purpose: Host side driving the port pins.
// Assumes: Pins change just after a rising edge.
// Notes:   Data is inverted as the cycle ends, since no hold is owed.
`timescale 1ns/1ps
module hpw_host_model (
    // Clock.
    input  wire        core_clk,
    // Host pins.
    output reg         bus_select_n,
    output reg         write_strobe_n,
    output reg         read_strobe_n,
    output reg         fifoDirectSel,
    output reg  [6:0]  hostAddr,
    output reg  [31:0] hostData
);
    // Pins start released.
    initial begin
        {bus_select_n, write_strobe_n, read_strobe_n} = 3'h7;
        {fifoDirectSel, hostAddr, hostData} = 40'h0;
    end
    // One cycle; lowCyc sets its length, relSel picks the pin that ends it.
    task hostCycle(input rd, input dir, input [6:0] a, input [31:0] d, input relSel,
                   input [3:0] lowCyc);
        begin
            @(posedge core_clk);
            {fifoDirectSel, hostAddr, hostData} <= {dir, a, d};
            bus_select_n <= 1'b0;
            write_strobe_n <= rd;
            read_strobe_n <= !rd;
            repeat (lowCyc) @(posedge core_clk);
            hostData <= ~d;
            if (relSel)
                bus_select_n <= 1'b1;
            else
                {write_strobe_n, read_strobe_n} <= 2'h3;
            repeat (3) @(posedge core_clk);
            {bus_select_n, write_strobe_n, read_strobe_n} <= 3'h7;
            @(posedge core_clk);
        end
    endtask
endmodule // hpw_host_model

/* File: bench/hpw_port_tb_top.sv */
// Purpose: Self-checking bench for the host write port.
// Assumes: Host model keeps the strobe spacing.
// Notes:   Output pulses are counted as they occur.
`timescale 1ns/1ps
module hpw_port_tb_top;
    reg          core_clk = 1'b0;
    reg          srst = 1'b1;
    reg          clkEn = 1'b1;
    reg          busWide = 1'b1;
    wire         bus_select_n, write_strobe_n, read_strobe_n, fifoDirectSel;
    wire         txPush, regWrite, rxPop, readActive;
    wire [6:0]   hostAddr, regAddr;
    wire [31:0]  hostData, txData, regData;
    wire [1:0]   rxLowAddr;
    integer      fail_count = 0, compares = 0, pushCnt = 0, regCnt = 0, popCnt = 0, i;
    integer      actCnt = 0;
    always #2.5 core_clk = ~core_clk;
    hpw_port i_dut (
        .core_clk       (core_clk),
        .srst           (srst),
        .clkEn          (clkEn),
        .bus_select_n   (bus_select_n),
        .write_strobe_n (write_strobe_n),
        .read_strobe_n  (read_strobe_n),
        .fifoDirectSel  (fifoDirectSel),
        .hostAddr       (hostAddr),
        .hostData       (hostData),
        .busWide        (busWide),
        .txPush         (txPush),
        .txData         (txData),
        .regWrite       (regWrite),
        .regAddr        (regAddr),
        .regData        (regData),
        .rxPop          (rxPop),
        .rxLowAddr      (rxLowAddr),
        .readActive     (readActive)
    );
    hpw_host_model i_host (
        .core_clk       (core_clk),
        .bus_select_n   (bus_select_n),
        .write_strobe_n (write_strobe_n),
        .read_strobe_n  (read_strobe_n),
        .fifoDirectSel  (fifoDirectSel),
        .hostAddr       (hostAddr),
        .hostData       (hostData)
    );
    // Count every output pulse.
    always @(posedge core_clk) begin
        if (!srst) begin
            pushCnt <= pushCnt + txPush;
            regCnt <= regCnt + regWrite;
            popCnt <= popCnt + rxPop;
            actCnt <= actCnt + readActive;
        end
    end
    task chk(input ok, input string msg);
        begin
            compares = compares + 1;
            if (ok !== 1'b1) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t %0s", $time, msg);
            end
        end
    endtask
    task close_out;
        begin
            $display("compares=%0d fail_count=%0d", compares, fail_count);
            if (fail_count == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task do_reset;
        begin
            @(posedge core_clk) srst <= 1'b1;
            repeat (5) @(posedge core_clk);
            srst <= 1'b0;
        end
    endtask
    // One write, then compare pulse counts and the delivered word.
    task wr(input dir, input [6:0] a, input [31:0] d, input tx, input [31:0] e, input [3:0] lc);
        integer p, r;
        begin
            p = pushCnt;
            r = regCnt;
            i_host.hostCycle(1'b0, dir, a, d, a[0], lc);
            #1;
            chk(pushCnt === p + tx && regCnt === r + !tx, "pulse count");
            chk((tx ? txData : regData) === e, "data word");
            if (!tx) chk(regAddr === a, "register address");
        end
    endtask
    // Direct writes push whatever the upper address, back to back.
    task t_direct;
        for (i = 0; i < 4; i = i + 1)
            wr(1'b1, 7'h7c ^ i[6:0] * 7'h15, 32'h1234_5670 + i, 1'b1, 32'h1234_5670 + i,
               i[1] ? 4'hc : 4'h7);
    endtask
    // Decoded writes: the FIFO window pushes, other addresses reach registers.
    task t_decode;
        begin
            wr(1'b0, 7'h13, 32'ha5a5_0001, 1'b1, 32'ha5a5_0001, 4'h7);
            wr(1'b0, 7'h20, 32'ha5a5_0002, 1'b0, 32'ha5a5_0002, 4'h7);
            wr(1'b0, 7'h0f, 32'ha5a5_0003, 1'b0, 32'ha5a5_0003, 4'h9);
        end
    endtask
    // A low clock enable freezes the port, so a whole write goes unseen.
    task t_freeze;
        integer p, r;
        begin
            p = pushCnt;
            r = regCnt;
            @(posedge core_clk) clkEn <= 1'b0;
            i_host.hostCycle(1'b0, 1'b1, 7'h00, 32'h0bad_0bad, 1'b0, 4'h7);
            @(posedge core_clk) clkEn <= 1'b1;
            repeat (6) @(posedge core_clk);
            #1;
            chk(pushCnt === p && regCnt === r, "write seen while frozen");
        end
    endtask
    // A narrow bus drops the upper half of the word.
    task t_half;
        begin
            @(posedge core_clk) busWide <= 1'b0;
            wr(1'b1, 7'h55, 32'hdead_beef, 1'b1, 32'h0000_beef, 4'h7);
            @(posedge core_clk) busWide <= 1'b1;
        end
    endtask
    // Direct burst reads pop once per cycle with the low address bits.
    // The read frame lasts as long as the host holds its pins low.
    task t_read;
        integer p, q;
        for (i = 0; i < 3; i = i + 1) begin
            p = popCnt;
            q = actCnt;
            i_host.hostCycle(1'b1, 1'b1, 7'h78 | i[6:0], 32'h0, 1'b0, 4'h7);
            #1;
            chk(popCnt === p + 1 && rxLowAddr === i[1:0], "read pop");
            chk(actCnt === q + 7, "read frame length");
        end
    endtask
    initial begin
        do_reset;
        t_direct;
        t_decode;
        t_freeze;
        t_half;
        do_reset;
        t_read;
        close_out;
    end
    // A hung run counts as a mismatch.
    initial begin
        #20000;
        fail_count = fail_count + 1;
        close_out;
    end
endmodule // hpw_port_tb_top
